// ===== design/rcs_ctrl_status.sv
// Control, status and power-fail supervision logic of the clock/calendar block.
`default_nettype none

// Summary of operation
// (R1) Supply fail blocks every register write.
// (R2) Writes stay blocked for a programmable recovery interval after supply returns.
// (R3) Supply fail forces the SRAM chip enable output high.
// (R4) An SRAM access in flight may finish, but for at most 30 us.
// (R5) On power-up the SRAM chip enable stays high for 200 ms.
// (R6) With good supply and no hold, chip enable input passes to output.
// (R7) Battery isolation holds until supply is first seen valid.
// (R8) All four control registers answer at any time, update or not.
// (R9) Rate select picks one of 13 taps for square wave and periodic flag.
// (R10) Code 010 runs oscillator and divider; 11X runs oscillator, divider held.
// (R11) Any other oscillator code keeps the oscillator stopped.
// (R12) First update follows 500 ms after writing 010.
// (R13) Update-in-progress is read-only, set before update, cleared after, zero under inhibit.
// (R14) Mode register fully read/write; soft reset clears the four enables only.
// (R15) Daylight-saving enable drives the October fall-back in the time block.
// (R16) Daylight-saving enable drives the April spring-forward in the time block.
// (R17) Bit 1 selects 24-hour (1) or 12-hour (0) format.
// (R18) Bit 2 selects binary (1) or BCD (0) encoding.
// (R19) Square wave follows selected tap when enabled, else held low.
// (R20) Transfer inhibit stops time copy and clears update interrupt enable.
// (R21) Update interrupt enable reads zero whenever transfer inhibit is one.
// (R22) Flags set on update end, alarm match and each periodic tick.
// (R23) Request flag sets when any flag and its enable are both one.
// (R24) Event register read-only, low nibble zero, reading clears all flags.
// (R25) Reading the event register releases the interrupt request pin.
// (R26) Validity register reads backup valid in bit 7, zeros below.
// (R27) An enabled set flag raises the interrupt request.
module rcs_ctrl_status #(
  parameter int OSC_DIV_CYC         = rcs_pkg::OSC_DIV_CYC,
  parameter int PROTECT_TIMEOUT_CYC = rcs_pkg::PROTECT_TIMEOUT_CYC,
  parameter int POWER_UP_HOLD_CYC   = rcs_pkg::POWER_UP_HOLD_CYC
) (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_I,
  input  wire logic        SOFT_RESET_I,
  input  wire logic [7:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  input  wire logic        SUPPLY_FAIL_I,
  input  wire logic        BACKUP_VALID_I,
  input  wire logic        SRAM_CE_N_I,
  input  wire logic        ALARM_MATCH_I,
  output logic             SRAM_CE_N_O,
  output logic             BACKUP_ISOLATE_O,
  output logic             SQUARE_WAVE_OUT_O,
  output logic             IRQ_N_O,
  output logic             IRQ_OE_O,
  output logic             OSC_ON_O,
  output logic             TIME_XFER_O,
  output logic             DAYLIGHT_SAVING_EN_O,
  output logic             HOUR_FORMAT_SEL_O,
  output logic             NUMBER_ENCODING_SEL_O
);

  // ---------------------------------------------------------------------------
  // Limits sized to the counters
  // ---------------------------------------------------------------------------
  localparam logic [12:0] OSC_DIV_LAST = 13'(OSC_DIV_CYC - 1);
  localparam logic [25:0] PROT_LAST    = 26'(PROTECT_TIMEOUT_CYC - 1);
  localparam logic [25:0] HOLD_LAST    = 26'(POWER_UP_HOLD_CYC - 1);

  rcs_pkg::rcs_state_s st_ff;
  rcs_pkg::rcs_state_s nxt_st;

  logic       req;
  logic       cap;
  logic       wr_go;
  logic [5:0] idx;
  logic [7:0] wdat;
  logic       wprot;
  logic       div_run;
  logic       adv;
  logic       tap;
  logic       ev_any;
  logic       clr_flags;

  // Tap bit index for rate codes 1..15; code 0 selects no tap.
  function automatic logic [3:0] tap_bit(input logic [3:0] r);
    tap_bit = (r <= 4'h2) ? 4'(r + 4'h5) : 4'(r - 4'h2);
  endfunction

  assign req     = AVS_READ_I | AVS_WRITE_I;
  assign idx     = AVS_ADDRESS_I[7:2];
  assign wdat    = AVS_WRITEDATA_I[7:0];
  assign cap     = req & ~st_ff.ack;
  assign wprot   = SUPPLY_FAIL_I | (st_ff.wp_cnt != 8'h00);
  assign wr_go   = st_ff.ack & AVS_WRITE_I & AVS_BYTEENABLE_I[0] & ~wprot; // R1 R2
  assign div_run = (st_ff.osc_ctrl == rcs_pkg::OSC_RUN_CODE); // R10
  assign adv     = st_ff.tick & div_run;
  assign tap     = (st_ff.rate != 4'h0) && st_ff.chain[tap_bit(st_ff.rate)]; // R9
  // The flag clear happens at the capture edge so that the value read and the
  // value cleared are the same; an event in that cycle survives the clear.
  assign clr_flags = (cap & AVS_READ_I & (idx == rcs_pkg::IDX_EVENT_FLAGS)) | SOFT_RESET_I;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.xfer = 1'b0;
    ev_any      = 1'b0;

    // -------------------------------------------------------------------------
    // Bus slave: one wait state, independent of the update cycle
    // -------------------------------------------------------------------------
    nxt_st.ack = cap; // R8
    if (cap) begin
      nxt_st.rdata = 8'h00;
      if (AVS_READ_I) begin
        unique case (idx)
          rcs_pkg::IDX_RATE_OSC:     nxt_st.rdata = {st_ff.update_in_progress, st_ff.osc_ctrl, st_ff.rate};
          rcs_pkg::IDX_MODE_IRQ:     nxt_st.rdata = st_ff.mode;
          rcs_pkg::IDX_EVENT_FLAGS:  nxt_st.rdata = {st_ff.irq_request_flag, st_ff.pf, st_ff.af,
                                                    st_ff.uf, 4'h0}; // R24
          rcs_pkg::IDX_BACKUP_VALID: nxt_st.rdata = {BACKUP_VALID_I, 7'h00}; // R26
          rcs_pkg::IDX_RECOVERY_CFG: nxt_st.rdata = st_ff.recov;
          default:                   nxt_st.rdata = 8'h00;
        endcase
      end
    end
    if (wr_go) begin
      if (idx == rcs_pkg::IDX_RATE_OSC) begin
        nxt_st.osc_ctrl = wdat[6:4]; // R13
        nxt_st.rate     = wdat[3:0];
        // A fresh start lands the chain half way, so the first wrap is 500 ms out.
        if (wdat[6:4] == rcs_pkg::OSC_RUN_CODE && !div_run) begin
          nxt_st.chain = rcs_pkg::CHAIN_HALF_SEC; // R12
        end
      end
      if (idx == rcs_pkg::IDX_MODE_IRQ) begin
        nxt_st.mode = wdat; // R14
      end
      if (idx == rcs_pkg::IDX_RECOVERY_CFG) begin
        nxt_st.recov = wdat;
      end
    end
    if (SOFT_RESET_I) begin
      nxt_st.mode = nxt_st.mode & rcs_pkg::SOFT_RST_MODE_KEEP; // R14
    end
    if (nxt_st.mode[rcs_pkg::MB_TRANSFER_INHIBIT]) begin
      nxt_st.mode[rcs_pkg::MB_UPDATE_IRQ_EN] = 1'b0; // R20 R21
    end
    nxt_st.osc_on = (nxt_st.osc_ctrl == rcs_pkg::OSC_RUN_CODE) ||
                    (nxt_st.osc_ctrl[2:1] == rcs_pkg::OSC_HOLD_TOP); // R10 R11

    // -------------------------------------------------------------------------
    // Timebase and update cycle
    // -------------------------------------------------------------------------
    nxt_st.tick    = 1'b0;
    nxt_st.osc_div = st_ff.osc_div + 13'h1;
    if (st_ff.osc_div == OSC_DIV_LAST) begin
      nxt_st.osc_div = 13'h0;
      nxt_st.tick    = 1'b1;
    end
    if (!div_run && !(wr_go && idx == rcs_pkg::IDX_RATE_OSC)) begin
      nxt_st.chain = 15'h0; // R10 R11
      nxt_st.update_in_progress   = 1'b0;
    end else if (adv) begin
      nxt_st.chain = st_ff.chain + 15'h1;
      if (st_ff.chain == rcs_pkg::CHAIN_UIP_LEAD) begin
        nxt_st.update_in_progress = 1'b1; // R13
      end
      if (st_ff.chain == rcs_pkg::CHAIN_LAST) begin
        nxt_st.update_in_progress  = 1'b0; // R13
        nxt_st.uf   = 1'b1; // R22
        nxt_st.xfer = ~st_ff.mode[rcs_pkg::MB_TRANSFER_INHIBIT]; // R20
        ev_any      = 1'b1;
      end
    end
    if (st_ff.mode[rcs_pkg::MB_TRANSFER_INHIBIT]) begin
      nxt_st.update_in_progress = 1'b0; // R13
    end
    nxt_st.tap_d = tap;

    // -------------------------------------------------------------------------
    // Event flags; a new event wins over a clear in the same cycle
    // -------------------------------------------------------------------------
    if (clr_flags) begin
      nxt_st.pf   = 1'b0; // R24
      nxt_st.af   = 1'b0;
      nxt_st.irq_request_flag = 1'b0; // R25
      if (!ev_any) begin
        nxt_st.uf = 1'b0;
      end
    end
    if (tap && !st_ff.tap_d) begin
      nxt_st.pf = 1'b1; // R22
      ev_any    = 1'b1;
    end
    if (ALARM_MATCH_I) begin
      nxt_st.af = 1'b1; // R22
      ev_any    = 1'b1;
    end
    if ((nxt_st.pf & nxt_st.mode[rcs_pkg::MB_PERIODIC_IRQ_EN]) |
        (nxt_st.af & nxt_st.mode[rcs_pkg::MB_ALARM_IRQ_EN]) |
        (nxt_st.uf & nxt_st.mode[rcs_pkg::MB_UPDATE_IRQ_EN])) begin
      nxt_st.irq_request_flag = 1'b1; // R23 R27
    end
    nxt_st.irq_oe = nxt_st.irq_request_flag; // R25 R27
    nxt_st.square_wave_out    = nxt_st.mode[rcs_pkg::MB_SQUARE_WAVE_EN] & tap; // R19

    // -------------------------------------------------------------------------
    // Power-fail supervision
    // -------------------------------------------------------------------------
    if (SUPPLY_FAIL_I) begin
      nxt_st.wp_cnt = st_ff.recov; // R2
    end else if (st_ff.tick && st_ff.wp_cnt != 8'h00) begin
      nxt_st.wp_cnt = st_ff.wp_cnt - 8'h1; // R2
    end
    if (!SUPPLY_FAIL_I) begin
      nxt_st.isolate = 1'b0; // R7
    end
    nxt_st.pcnt = st_ff.pcnt + 26'h1;
    unique case (st_ff.pstate)
      rcs_pkg::PWR_VALID: begin
        nxt_st.ce_n = SRAM_CE_N_I; // R6
        nxt_st.pcnt = 26'h0;
        if (SUPPLY_FAIL_I) begin
          nxt_st.pstate = SRAM_CE_N_I ? rcs_pkg::PWR_FAIL : rcs_pkg::PWR_DRAIN; // R3 R4
          nxt_st.ce_n   = 1'b1;
          if (!SRAM_CE_N_I) begin
            nxt_st.ce_n = 1'b0; // R4
          end
        end
      end
      rcs_pkg::PWR_DRAIN: begin
        // Only the access already running may continue; a new one cannot start.
        nxt_st.ce_n = SRAM_CE_N_I;
        if (SRAM_CE_N_I || st_ff.pcnt == PROT_LAST) begin
          nxt_st.pstate = rcs_pkg::PWR_FAIL; // R4
          nxt_st.ce_n   = 1'b1;
        end
      end
      rcs_pkg::PWR_FAIL: begin
        nxt_st.ce_n = 1'b1; // R3
        nxt_st.pcnt = 26'h0;
        if (!SUPPLY_FAIL_I) begin
          nxt_st.pstate = rcs_pkg::PWR_HOLD;
        end
      end
      rcs_pkg::PWR_HOLD: begin
        nxt_st.ce_n = 1'b1; // R5
        if (SUPPLY_FAIL_I) begin
          nxt_st.pstate = rcs_pkg::PWR_FAIL;
          nxt_st.pcnt   = 26'h0;
        end else if (st_ff.pcnt == HOLD_LAST) begin
          nxt_st.pstate = rcs_pkg::PWR_VALID; // R5
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      st_ff          <= '0;
      st_ff.osc_ctrl <= rcs_pkg::RST_OSC_CTRL;
      st_ff.rate     <= rcs_pkg::RST_RATE;
      st_ff.mode     <= rcs_pkg::RST_MODE;
      st_ff.recov    <= rcs_pkg::RST_RECOVERY;
      st_ff.wp_cnt   <= rcs_pkg::RST_RECOVERY;
      st_ff.pstate   <= rcs_pkg::PWR_FAIL;
      st_ff.ce_n     <= 1'b1;
      st_ff.isolate  <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign AVS_READDATA_O        = {24'h000000, st_ff.rdata};
  assign AVS_WAITREQUEST_O     = ~st_ff.ack;
  assign SRAM_CE_N_O           = st_ff.ce_n;
  assign BACKUP_ISOLATE_O      = st_ff.isolate;
  assign SQUARE_WAVE_OUT_O     = st_ff.square_wave_out;
  assign IRQ_N_O               = 1'b0;
  assign IRQ_OE_O              = st_ff.irq_oe;
  assign OSC_ON_O              = st_ff.osc_on;
  assign TIME_XFER_O           = st_ff.xfer;
  assign DAYLIGHT_SAVING_EN_O  = st_ff.mode[rcs_pkg::MB_DAYLIGHT_SAVING_EN]; // R15 R16
  assign HOUR_FORMAT_SEL_O     = st_ff.mode[rcs_pkg::MB_HOUR_FORMAT_SEL]; // R17
  assign NUMBER_ENCODING_SEL_O = st_ff.mode[rcs_pkg::MB_NUMBER_ENCODING_SEL]; // R18

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  a_fail_write_block: assert property ( // R1
    (st_ff.ack && AVS_WRITE_I && SUPPLY_FAIL_I && idx == rcs_pkg::IDX_MODE_IRQ && !SOFT_RESET_I)
      |=> $stable(st_ff.mode))
    else $error("Mode register changed during supply fail.");
  a_recovery_wait: assert property ( // R2
    $fell(SUPPLY_FAIL_I) && st_ff.recov != 8'h00 |-> wprot)
    else $error("Write protection dropped with supply return.");
  a_ce_fail_high: assert property ( // R3
    st_ff.pstate == rcs_pkg::PWR_FAIL && $past(st_ff.pstate) == rcs_pkg::PWR_FAIL
      |-> SRAM_CE_N_O)
    else $error("Chip enable active during supply fail.");
  a_drain_bounded: assert property ( // R4
    st_ff.pstate == rcs_pkg::PWR_DRAIN |-> st_ff.pcnt <= PROT_LAST)
    else $error("SRAM access drain exceeded its limit.");
  a_hold_ce_high: assert property ( // R5
    st_ff.pstate == rcs_pkg::PWR_HOLD |-> SRAM_CE_N_O)
    else $error("Chip enable active during power-up hold.");
  a_ce_pass_thru: assert property ( // R6
    st_ff.pstate == rcs_pkg::PWR_VALID && $past(st_ff.pstate) == rcs_pkg::PWR_VALID
      |-> SRAM_CE_N_O == $past(SRAM_CE_N_I))
    else $error("Chip enable not passed through.");
  a_uip_inhibit: assert property ( // R13
    st_ff.mode[rcs_pkg::MB_TRANSFER_INHIBIT] |=> !st_ff.update_in_progress)
    else $error("Update in progress set under transfer inhibit.");
  a_uie_inhibit: assert property ( // R21
    st_ff.mode[rcs_pkg::MB_TRANSFER_INHIBIT] |-> !st_ff.mode[rcs_pkg::MB_UPDATE_IRQ_EN])
    else $error("Update enable set under transfer inhibit.");
  a_sqw_held_low: assert property ( // R19
    !st_ff.mode[rcs_pkg::MB_SQUARE_WAVE_EN] |-> !SQUARE_WAVE_OUT_O)
    else $error("Square wave active while disabled.");
  a_irq_request_flag_cause: assert property ( // R23
    (st_ff.pf && st_ff.mode[rcs_pkg::MB_PERIODIC_IRQ_EN]) ||
    (st_ff.uf && st_ff.mode[rcs_pkg::MB_UPDATE_IRQ_EN]) |-> st_ff.irq_request_flag && IRQ_OE_O)
    else $error("Request flag missing for an enabled event.");
  a_read_clears: assert property ( // R24
    clr_flags && !ev_any |=> !st_ff.pf && !st_ff.af && !st_ff.uf && !IRQ_OE_O ##1 1'b1)
    else $error("Event register read did not clear the flags.");
  a_first_update: assert property ( // R12
    wr_go && idx == rcs_pkg::IDX_RATE_OSC && wdat[6:4] == rcs_pkg::OSC_RUN_CODE && !div_run
      |=> st_ff.chain == rcs_pkg::CHAIN_HALF_SEC)
    else $error("First update not placed 500 ms out.");

  c_read_flags:  cover property (clr_flags && st_ff.irq_request_flag);
  c_drain_done:  cover property (st_ff.pstate == rcs_pkg::PWR_DRAIN ##1
                                 st_ff.pstate == rcs_pkg::PWR_FAIL);
  c_hold_done:   cover property (st_ff.pstate == rcs_pkg::PWR_HOLD ##1
                                 st_ff.pstate == rcs_pkg::PWR_VALID);
  c_update_xfer: cover property (st_ff.xfer);

endmodule // rcs_ctrl_status
`default_nettype wire

// ===== design/rcs_pkg.sv
// Package of constants and types for the clock control, status and power-fail block.
`default_nettype none
package rcs_pkg;

  // ---------------------------------------------------------------------------
  // Clock and time constants
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ                     = 250_000_000;
  localparam int CLK_PERIOD_NS              = 4;
  localparam int OSC_HZ                     = 32_768;
  localparam int OSC_DIV_CYC                = CLK_HZ / OSC_HZ;
  localparam int PROTECT_TIMEOUT_NS         = 30_000;
  localparam int PROTECT_TIMEOUT_CYC        = PROTECT_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int POWER_UP_HOLD_TIME_MS      = 200;
  localparam int POWER_UP_HOLD_CYC          = (POWER_UP_HOLD_TIME_MS * 1_000_000) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ---------------------------------------------------------------------------
  localparam logic [5:0] IDX_RATE_OSC       = 6'h0A;
  localparam logic [5:0] IDX_MODE_IRQ       = 6'h0B;
  localparam logic [5:0] IDX_EVENT_FLAGS    = 6'h0C;
  localparam logic [5:0] IDX_BACKUP_VALID   = 6'h0D;
  localparam logic [5:0] IDX_RECOVERY_CFG   = 6'h0E;

  // ---------------------------------------------------------------------------
  // Field positions of the mode register
  // ---------------------------------------------------------------------------
  localparam int MB_TRANSFER_INHIBIT        = 7;
  localparam int MB_PERIODIC_IRQ_EN         = 6;
  localparam int MB_ALARM_IRQ_EN            = 5;
  localparam int MB_UPDATE_IRQ_EN           = 4;
  localparam int MB_SQUARE_WAVE_EN          = 3;
  localparam int MB_NUMBER_ENCODING_SEL     = 2;
  localparam int MB_HOUR_FORMAT_SEL         = 1;
  localparam int MB_DAYLIGHT_SAVING_EN      = 0;

  // ---------------------------------------------------------------------------
  // Oscillator control codes and divider chain points
  // ---------------------------------------------------------------------------
  localparam logic [2:0]  OSC_RUN_CODE      = 3'h2;
  localparam logic [1:0]  OSC_HOLD_TOP      = 2'h3;
  localparam logic [14:0] CHAIN_HALF_SEC    = 15'h4000;
  localparam logic [14:0] CHAIN_UIP_LEAD    = 15'h7FF8;
  localparam logic [14:0] CHAIN_LAST        = 15'h7FFF;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [2:0] RST_OSC_CTRL       = 3'h0;
  localparam logic [3:0] RST_RATE           = 4'h0;
  localparam logic [7:0] RST_MODE           = 8'h00;
  localparam logic [7:0] RST_RECOVERY       = 8'h10;
  localparam logic [7:0] SOFT_RST_MODE_KEEP = 8'h87;

  typedef enum logic [1:0] {
    PWR_VALID,
    PWR_DRAIN,
    PWR_FAIL,
    PWR_HOLD
  } rcs_pwr_e;

  typedef struct packed {
    logic        ack;
    logic [7:0]  rdata;
    logic [2:0]  osc_ctrl;
    logic [3:0]  rate;
    logic        update_in_progress;
    logic [7:0]  mode;
    logic        irq_request_flag;
    logic        pf;
    logic        af;
    logic        uf;
    logic [7:0]  recov;
    logic [7:0]  wp_cnt;
    logic [12:0] osc_div;
    logic        tick;
    logic [14:0] chain;
    logic        tap_d;
    rcs_pwr_e    pstate;
    logic [25:0] pcnt;
    logic        ce_n;
    logic        isolate;
    logic        square_wave_out;
    logic        irq_oe;
    logic        xfer;
    logic        osc_on;
  } rcs_state_s;

endpackage
`default_nettype wire

// ===== dv/rcs_sram_host.sv
// Host-side model that drives the SRAM chip enable into the block.
`default_nettype none
module rcs_sram_host (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] len_i,
  output logic            ce_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_ff = 8'h00;
  // The enable line has a pull-up, so an idle host leaves it high.
  assign ce_n_o = (left_ff == 8'h00);
  always_ff @(posedge clk_i) begin
    if (go_i) begin
      left_ff <= len_i;
    end else if (left_ff != 8'h00) begin
      left_ff <= left_ff - 8'h01;
    end
  end
endmodule // rcs_sram_host
`default_nettype wire

// ===== dv/rtc_control_status_powerfail_tb.sv
// Self-checking bench of the clock control, status and power-fail block.
`default_nettype none
module rtc_control_status_powerfail_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, sfail = 1'b1, bvalid = 1'b1, alarm = 1'b0;
  logic        rd = 1'b0, wr = 1'b0, go = 1'b0, srst = 1'b0;
  logic [7:0]  addr = 8'h00, len = 8'h00;
  logic [31:0] wdata = 32'h0, rd_data, rdata;
  logic        wait_req, ce_in, ce_out, iso, square_wave_out, irq_n, irq_oe, osc_on, xfer, daylight_saving_en, hf, df;
  int          mismatches = 0, samples_checked = 0, cycles = 0, n;

  rcs_sram_host u_host (.clk_i(clk), .go_i(go), .len_i(len), .ce_n_o(ce_in));

  // Long counts are shortened so the whole run stays near 66k cycles.
  rcs_ctrl_status #(
    .OSC_DIV_CYC        (4),
    .PROTECT_TIMEOUT_CYC(20),
    .POWER_UP_HOLD_CYC  (50)
  ) u_dut (
    .CLK_SYS_I            (clk),
    .RST_I                (rst),
    .SOFT_RESET_I         (srst),
    .AVS_ADDRESS_I        (addr),
    .AVS_READ_I           (rd),
    .AVS_WRITE_I          (wr),
    .AVS_WRITEDATA_I      (wdata),
    .AVS_BYTEENABLE_I     (4'hF),
    .AVS_READDATA_O       (rd_data),
    .AVS_WAITREQUEST_O    (wait_req),
    .SUPPLY_FAIL_I        (sfail),
    .BACKUP_VALID_I       (bvalid),
    .SRAM_CE_N_I          (ce_in),
    .ALARM_MATCH_I        (alarm),
    .SRAM_CE_N_O          (ce_out),
    .BACKUP_ISOLATE_O     (iso),
    .SQUARE_WAVE_OUT_O    (square_wave_out),
    .IRQ_N_O              (irq_n),
    .IRQ_OE_O             (irq_oe),
    .OSC_ON_O             (osc_on),
    .TIME_XFER_O          (xfer),
    .DAYLIGHT_SAVING_EN_O (daylight_saving_en),
    .HOUR_FORMAT_SEL_O    (hf),
    .NUMBER_ENCODING_SEL_O(df)
  );

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic stop_test();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // A fresh edge starts every access, so a release is never undone in the same step.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (wait_req !== 1'b0);
    rdata = rd_data;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rdata, {24'h0, exp});
  endtask

  task automatic hit();
    alarm <= 1'b1;
    @(posedge clk);
    alarm <= 1'b0;
    cyc(3);
  endtask

  task automatic rises(output int k);
    logic last;
    k = 0;
    last = square_wave_out;
    repeat (64) begin
      @(posedge clk);
      if (square_wave_out === 1'b1 && last === 1'b0) k++;
      last = square_wave_out;
    end
  endtask

  // ---------------------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------------------
  initial begin
    cyc(5);
    rst <= 1'b0;
    cyc(2);
    chk({31'h0, iso}, 32'h1);
    chk({31'h0, ce_out}, 32'h1);
    bus(1'b1, 8'h2C, 8'h0F);
    rchk(8'h2C, 8'h00);
    sfail <= 1'b0;
    go <= 1'b1;
    len <= 8'h3C;
    @(posedge clk);
    go <= 1'b0;
    cyc(3);
    chk({31'h0, iso}, 32'h0);
    cyc(35);
    chk({31'h0, ce_out}, 32'h1);
    cyc(17);
    chk({31'h0, ce_out}, 32'h0);
    cyc(30);
    rchk(8'h34, 8'h80);
    bvalid <= 1'b0;
    bus(1'b1, 8'h34, 8'hFF);
    rchk(8'h34, 8'h00);
    bvalid <= 1'b1;
    rchk(8'h3C, 8'h00);
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 8'h28, {1'b1, c[2:0], 4'h5});
      rchk(8'h28, {1'b0, c[2:0], 4'h5});
      chk({31'h0, osc_on}, {31'h0, (c == 2 || c >= 6)});
    end
    bus(1'b1, 8'h28, 8'h00);
    bus(1'b0, 8'h30, 8'h00);
    bus(1'b1, 8'h2C, 8'hFF);
    rchk(8'h2C, 8'hEF);
    chk({29'h0, df, hf, daylight_saving_en}, 32'h7);
    // The device reset pin keeps the inhibit and format bits, drops the four enables.
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rchk(8'h2C, 8'h87);
    bus(1'b1, 8'h2C, 8'h7E);
    rchk(8'h2C, 8'h7E);
    chk({29'h0, df, hf, daylight_saving_en}, 32'h6);
    bus(1'b1, 8'h2C, 8'h00);
    hit();
    chk({31'h0, irq_oe}, 32'h0);
    rchk(8'h30, 8'h20);
    bus(1'b1, 8'h2C, 8'h20);
    hit();
    chk({31'h0, irq_oe}, 32'h1);
    rchk(8'h30, 8'hA0);
    cyc(1);
    chk({31'h0, irq_oe}, 32'h0);
    chk({31'h0, irq_n}, 32'h0);
    rchk(8'h30, 8'h00);
    bus(1'b1, 8'h2C, 8'h08);
    bus(1'b1, 8'h28, 8'h23);
    rises(n);
    chk(n, 4);
    bus(1'b1, 8'h2C, 8'h00);
    cyc(2);
    rises(n);
    chk({31'h0, square_wave_out}, 32'h0);
    chk(n, 0);
    rchk(8'h30, 8'h40);
    bus(1'b1, 8'h2C, 8'h40);
    cyc(20);
    chk({31'h0, irq_oe}, 32'h1);
    rchk(8'h30, 8'hC0);
    bus(1'b1, 8'h28, 8'h00);
    bus(1'b1, 8'h2C, 8'h00);
    bus(1'b0, 8'h30, 8'h00);
    go <= 1'b1;
    len <= 8'h28;
    @(posedge clk);
    go <= 1'b0;
    cyc(5);
    chk({31'h0, ce_out}, 32'h0);
    sfail <= 1'b1;
    cyc(10);
    chk({31'h0, ce_out}, 32'h0);
    cyc(15);
    chk({31'h0, ce_out}, 32'h1);
    bus(1'b1, 8'h2C, 8'h0F);
    rchk(8'h2C, 8'h00);
    sfail <= 1'b0;
    bus(1'b1, 8'h2C, 8'h0F);
    rchk(8'h2C, 8'h00);
    go <= 1'b1;
    len <= 8'h14;
    @(posedge clk);
    go <= 1'b0;
    cyc(5);
    chk({31'h0, ce_out}, 32'h1);
    cyc(100);
    bus(1'b1, 8'h2C, 8'h0F);
    rchk(8'h2C, 8'h0F);
    bus(1'b1, 8'h2C, 8'h10);
    bus(1'b1, 8'h28, 8'h20);
    cyc(65510);
    rchk(8'h28, 8'hA0);
    n = 0;
    while (xfer !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, (n >= 15 && n <= 35)}, 32'h1);
    cyc(3);
    chk({31'h0, irq_oe}, 32'h1);
    rchk(8'h28, 8'h20);
    rchk(8'h30, 8'h90);
    bus(1'b1, 8'h2C, 8'h90);
    rchk(8'h2C, 8'h80);
    stop_test();
  end
endmodule // rtc_control_status_powerfail_tb
`default_nettype wire
